// file: bench/tb_top.sv
`timescale 1ns/10ps
`include "event_word_defs.svh"

module tb_top
  import event_word_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         rst_n;
  logic [7:0]   paddr;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  alarmIn;
  counter_evt_s cntEvt;
  logic         hardwareCountGate;
  logic         softwareCountGate;
  diag_in_s     diagIn;
  logic         processIrqHandler;
  logic [15:0]  handlerBaseAddr;
  logic [31:0]  eventWord;
  logic         irq;
  logic [31:0]  seed = 32'hed5a_0ca1;
  logic [31:0]  r;
  logic [31:0]  rd;
  logic         err;
  logic         got;
  logic [15:0]  base;
  counter_evt_s ev;
  int           errTotal = 0;
  int           nTests = 0;

  always #5 core_clk = ~core_clk;

  process_interrupt_event_word process_interrupt_event_word_inst (
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarmIn(alarmIn), .cntEvt(cntEvt),
    .hardwareCountGate(hardwareCountGate), .softwareCountGate(softwareCountGate),
    .diagIn(diagIn), .processIrqHandler(processIrqHandler),
    .handlerBaseAddr(handlerBaseAddr), .eventWord(eventWord), .irq(irq)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Counter layout: byte 8 in the top byte, counter 3 in the bottom byte
  function automatic logic [31:0] cnt_word(counter_evt_s e, logic go, logic gc);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < 4; i++) begin
      w[26 - 8 * i] = e.ovf[i];
      w[27 - 8 * i] = e.cmp[i];
    end
    w[4] = e.latch3;
    w[0] = go;
    w[1] = gc;
    return w;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errTotal++;
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task automatic pulse(input counter_evt_s e, input logic [15:0] tg, input logic hg);
    cntEvt <= e;
    alarmIn <= alarmIn ^ tg;
    hardwareCountGate <= hg;
    @(posedge core_clk);
    cntEvt <= '0;
  endtask

  task automatic wait_call(output logic seen);
    seen = 1'b0;
    for (int n = 0; n < 12 && !seen; n++) begin
      @(posedge core_clk);
      seen = (processIrqHandler === 1'b1);
    end
  endtask

  task automatic fire(input counter_evt_s e, input logic [15:0] tg, input logic hg,
                      input logic want, input logic [31:0] expW);
    logic seen;
    pulse(e, tg, hg);
    wait_call(seen);
    chk("handler_call", {31'h0, want}, {31'h0, seen});
    if (seen) begin
      chk("event_word", expW, eventWord);
      chk("base_addr", {16'h0, base}, {16'h0, handlerBaseAddr});
      apb(1'b1, `OFS_HANDLER_END, 32'h1);
      chk("word_cleared", 32'h0, eventWord);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
    alarmIn = '0;
    cntEvt = '0;
    hardwareCountGate = 1'b0;
    softwareCountGate = 1'b1;
    diagIn = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("word_reset", 32'h0, eventWord);
    chk("irq_reset", 32'h0, {31'h0, irq});
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    r = rnd();
    base = r[15:0];
    apb(1'b1, `OFS_BASE_ADDR, {16'h0, base});
    // Selections other than diagnostics plus process stay silent
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `OFS_CTRL, 32'h0000_3F7C | 32'(s));
      fire('{1'b0, 4'h0, 4'h1}, 16'h0, 1'b0, 1'b0, 32'h0);
    end
    apb(1'b1, `OFS_CTRL, 32'h0000_3F7E);
    for (int k = 0; k < 10; k++) begin
      r = rnd();
      if (r[8:0] == '0) r[0] = 1'b1;
      ev = r[8:0];
      fire(ev, 16'h0, 1'b0, 1'b1, cnt_word(ev, 1'b0, 1'b0));
    end
    fire('0, 16'h0, 1'b1, 1'b1, 32'h1);
    fire('0, 16'h0, 1'b0, 1'b1, 32'h2);
    // Repeat of a held event is merged and flagged lost
    pulse('{1'b0, 4'h0, 4'h1}, 16'h0, 1'b0);
    wait_call(got);
    pulse('{1'b0, 4'h0, 4'h1}, 16'h0, 1'b0);
    repeat (3) @(posedge core_clk);
    chk("word_held", 32'h0400_0000, eventWord);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("lost_flag", 32'h3, rd & 32'h3);
    apb(1'b1, `OFS_HANDLER_END, 32'h1);
    wait_call(got);
    chk("no_extra_call", 32'h0, {31'h0, got});
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h7F);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("status_clear", 32'h0, rd);
    for (int k = 0; k < 5; k++) begin
      diagIn <= 5'(1 << k);
      @(posedge core_clk);
      diagIn <= '0;
      @(posedge core_clk);
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
      chk("diag_status", 32'(1 << (k + 2)), rd);
      apb(1'b1, `OFS_IRQ_CLEAR, 32'h7F);
    end
    apb(1'b1, `OFS_CTRL, 32'h0000_3F7A);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      if (r[15:0] == '0) r[0] = 1'b1;
      fire('0, r[15:0], 1'b0, 1'b1, {r[7:0], r[15:8], 16'h0});
    end
    // Disabled triggers and a closed software gate stay silent
    apb(1'b1, `OFS_CTRL, 32'h0000_3F72);
    fire('0, 16'h00FF, 1'b0, 1'b0, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h0000_3F06);
    fire('{1'b0, 4'hF, 4'hF}, 16'h0, 1'b1, 1'b0, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h0000_3F46);
    softwareCountGate <= 1'b0;
    fire('0, 16'h0, 1'b0, 1'b0, 32'h0);
    softwareCountGate <= 1'b1;
    fire('0, 16'h0, 1'b1, 1'b1, 32'h1);
    wrap_up();
  end
endmodule

// file: hw/event_word_defs.svh
`ifndef EVENT_WORD_DEFS_SVH
`define EVENT_WORD_DEFS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_BASE_ADDR   8'h04
`define OFS_EVENT_WORD  8'h08
`define OFS_HANDLER_END 8'h0C
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_CLEAR   8'h14
`define OFS_IRQ_ENABLE  8'h18

// Control register fields
`define CTRL_SEL_LSB    0
`define CTRL_SEL_MSB    1
`define CTRL_MODE_BIT   2
`define CTRL_TRG_EDGE   3
`define CTRL_TRG_CMP    4
`define CTRL_TRG_OVF    5
`define CTRL_TRG_GATE   6
`define CTRL_DIAG_LSB   8
`define CTRL_DIAG_MSB   13
`define CTRL_RESET      32'h0000_0000

// Interrupt selection codes
`define SEL_NONE        2'h0
`define SEL_DIAG        2'h1
`define SEL_DIAG_PROC   2'h2

// Bit positions inside one byte of the event word
`define EVB_GATE_OPEN   0
`define EVB_GATE_CLOSE  1
`define EVB_OVF         2
`define EVB_CMP         3
`define EVB_LATCH       4

// Bits that stay zero in counter mode
`define COUNTER_ZERO_MASK 32'hF3F3_F3E0

// Sticky status bits
`define NUM_STATUS      7
`define STB_PROC        0
`define STB_LOST        1
`define STB_OUT_SUPPLY  2
`define STB_BUS_SUPPLY  3
`define STB_IN_SUPPLY   4
`define STB_SENSOR_SC   5
`define STB_OUTPUT_SC   6

`endif

// file: hw/event_word_pkg.sv
package event_word_pkg;

  typedef enum logic {
    MODE_ALARM,
    MODE_COUNTER
  } word_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CALL,
    ST_HELD
  } handler_state_e;

  typedef struct packed {
    logic       latch3;
    logic [3:0] cmp;
    logic [3:0] ovf;
  } counter_evt_s;

  typedef struct packed {
    logic outputShort;
    logic sensorShort;
    logic inputSupplyLost;
    logic busSupplyLost;
    logic outputSupplyLost;
  } diag_in_s;

endpackage

// file: hw/process_interrupt_event_word.sv
// Functional notes
// - A process interrupt is raised only while interrupt selection is diagnostics plus process.
// - Each process interrupt calls the handler and hands it the module base address.
// - Event detail is a 32-bit word whose layout follows the configured operating mode.
// - In alarm mode byte 8 bits 0..7 flag edges on alarm inputs 0..7.
// - In alarm mode byte 9 flags edges on alarm inputs 8..15 and bytes 10, 11 read zero.
// - In counter mode bit 2 of bytes 8..10 flags counter 0..2 over/underflow, bits 0,1,4..7 zero.
// - In counter mode bit 3 of bytes 8..10 flags counter 0..2 compare match.
// - Byte 11 bits 0 and 1 flag counter 3 gate opened and gate closed.
// - Byte 11 bits 2,3,4 flag counter 3 over/underflow, compare, new latch; bits 5..7 zero.
// - An edge on an alarm input is a selectable trigger.
// - A counter reaching its compare value is a selectable trigger.
// - Counter overflow and underflow are selectable triggers.
// - Hardware gate open and close, while the software gate is open, are selectable triggers.
// - Diagnostic interrupts can be enabled for lost interrupt, supply losses and short circuits.
`timescale 1ns/10ps
`include "event_word_defs.svh"

module process_interrupt_event_word
  import event_word_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // APB slave
  input  wire logic [7:0]   paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Process and diagnostic sources
  input  wire logic [15:0]  alarmIn,
  input  wire counter_evt_s cntEvt,
  input  wire logic         hardwareCountGate,
  input  wire logic         softwareCountGate,
  input  wire diag_in_s     diagIn,
  // Handler side
  output logic              processIrqHandler,
  output logic [15:0]       handlerBaseAddr,
  output logic [31:0]       eventWord,
  output logic              irq
);

  logic [31:0]             ctrl;
  logic [15:0]             baseAddr;
  logic [`NUM_STATUS-1:0]  irqStatus;
  logic [`NUM_STATUS-1:0]  irqEnable;
  logic [15:0]             alarmPrev;
  logic                    gatePrev;
  logic [31:0]             pending;
  handler_state_e          state;

  logic [31:0]             next_ctrl;
  logic [15:0]             next_baseAddr;
  logic [`NUM_STATUS-1:0]  next_irqStatus;
  logic [`NUM_STATUS-1:0]  next_irqEnable;
  logic [31:0]             next_prdata;
  logic [31:0]             next_pending;
  logic [31:0]             next_eventWord;
  logic [15:0]             next_handlerBaseAddr;
  handler_state_e          next_state;

  logic                    wrAcc;
  logic                    rdSetup;
  logic                    mapped;
  logic                    endWrite;
  logic                    procOn;
  word_mode_e              mode;
  logic [15:0]             alarmEdge;
  logic                    gateOpenEv;
  logic                    gateCloseEv;
  logic [31:0]             rawWord;
  logic [31:0]             newEv;
  logic                    lostEv;
  logic [`NUM_STATUS-1:0]  setBits;
  logic [5:0]              diagEn;

  // Bus decode, zero wait states
  assign wrAcc    = psel && penable && pwrite;
  assign rdSetup  = psel && !penable && !pwrite;
  assign mapped   = paddr == `OFS_CTRL || paddr == `OFS_BASE_ADDR
                 || paddr == `OFS_EVENT_WORD || paddr == `OFS_HANDLER_END
                 || paddr == `OFS_IRQ_STATUS || paddr == `OFS_IRQ_CLEAR
                 || paddr == `OFS_IRQ_ENABLE;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign endWrite = wrAcc && paddr == `OFS_HANDLER_END && pwdata[0];

  assign procOn = ctrl[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == `SEL_DIAG_PROC;
  assign mode   = ctrl[`CTRL_MODE_BIT] ? MODE_COUNTER : MODE_ALARM;
  assign diagEn = ctrl[`CTRL_DIAG_MSB:`CTRL_DIAG_LSB];

  // Source edge detection
  assign alarmEdge   = alarmIn ^ alarmPrev;
  assign gateOpenEv  = hardwareCountGate && !gatePrev && softwareCountGate;
  assign gateCloseEv = !hardwareCountGate && gatePrev && softwareCountGate;

  // Event word layout, byte 8 in the top lane
  always_comb begin
    rawWord = 32'h0000_0000;
    if (mode == MODE_ALARM) begin
      if (ctrl[`CTRL_TRG_EDGE]) begin
        rawWord[31:24] = alarmEdge[7:0];
        rawWord[23:16] = alarmEdge[15:8];
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        rawWord[8*(3-i)+`EVB_OVF] = cntEvt.ovf[i] && ctrl[`CTRL_TRG_OVF];
        rawWord[8*(3-i)+`EVB_CMP] = cntEvt.cmp[i] && ctrl[`CTRL_TRG_CMP];
      end
      rawWord[`EVB_GATE_OPEN]  = gateOpenEv && ctrl[`CTRL_TRG_GATE];
      rawWord[`EVB_GATE_CLOSE] = gateCloseEv && ctrl[`CTRL_TRG_GATE];
      rawWord[`EVB_LATCH]      = cntEvt.latch3;
    end
  end

  assign newEv  = procOn ? rawWord : 32'h0000_0000;
  assign lostEv = state != ST_IDLE && |(newEv & (eventWord | pending));

  // Handler sequencing
  always_comb begin
    next_state           = state;
    // Repeats of a held event are only flagged lost, never called again
    next_pending         = pending | (newEv & ~eventWord);
    next_eventWord       = eventWord;
    next_handlerBaseAddr = handlerBaseAddr;
    case (state)
      ST_IDLE: begin
        if (next_pending != 32'h0000_0000) begin
          next_eventWord       = next_pending;
          next_handlerBaseAddr = baseAddr;
          next_pending         = 32'h0000_0000;
          next_state           = ST_CALL;
        end
      end
      ST_CALL: begin
        next_state = ST_HELD;
      end
      ST_HELD: begin
        if (endWrite) begin
          next_eventWord = 32'h0000_0000;
          next_state     = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign processIrqHandler = state == ST_CALL;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      pending         <= 32'h0000_0000;
      eventWord       <= 32'h0000_0000;
      handlerBaseAddr <= 16'h0000;
      alarmPrev       <= 16'h0000;
      gatePrev        <= 1'b0;
    end else begin
      state           <= next_state;
      pending         <= next_pending;
      eventWord       <= next_eventWord;
      handlerBaseAddr <= next_handlerBaseAddr;
      alarmPrev       <= alarmIn;
      gatePrev        <= hardwareCountGate;
    end
  end

  // Sticky status, set wins over clear
  assign setBits = {
    diagIn.outputShort      && diagEn[5],
    diagIn.sensorShort      && diagEn[4],
    diagIn.inputSupplyLost  && diagEn[3],
    diagIn.busSupplyLost    && diagEn[2],
    diagIn.outputSupplyLost && diagEn[1],
    lostEv                  && diagEn[0],
    processIrqHandler
  };

  // Register file
  always_comb begin
    next_ctrl      = ctrl;
    next_baseAddr  = baseAddr;
    next_irqEnable = irqEnable;
    next_irqStatus = irqStatus;
    next_prdata    = prdata;
    if (wrAcc) begin
      case (paddr)
        `OFS_CTRL:       next_ctrl      = pwdata & 32'h0000_3F7F;
        `OFS_BASE_ADDR:  next_baseAddr  = pwdata[15:0];
        `OFS_IRQ_CLEAR:  next_irqStatus = irqStatus & ~pwdata[`NUM_STATUS-1:0];
        `OFS_IRQ_ENABLE: next_irqEnable = pwdata[`NUM_STATUS-1:0];
        default:         next_ctrl      = ctrl;
      endcase
    end
    next_irqStatus = next_irqStatus | setBits;
    if (rdSetup) begin
      case (paddr)
        `OFS_CTRL:        next_prdata = ctrl;
        `OFS_BASE_ADDR:   next_prdata = {16'h0000, baseAddr};
        `OFS_EVENT_WORD:  next_prdata = eventWord;
        `OFS_HANDLER_END: next_prdata = {31'h0000_0000, state != ST_IDLE};
        `OFS_IRQ_STATUS:  next_prdata = {25'h000_0000, irqStatus};
        `OFS_IRQ_ENABLE:  next_prdata = {25'h000_0000, irqEnable};
        default:          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= `CTRL_RESET;
      baseAddr  <= 16'h0000;
      irqStatus <= '0;
      irqEnable <= '0;
      prdata    <= 32'h0000_0000;
    end else begin
      ctrl      <= next_ctrl;
      baseAddr  <= next_baseAddr;
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
      prdata    <= next_prdata;
    end
  end

  assign irq = |(irqStatus & irqEnable);

  // Checks
  logic fresh;
  assign fresh = state == ST_IDLE && pending == 32'h0000_0000 && procOn;

  chk_sel_gates_proc: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_IDLE && pending == 32'h0000_0000 && !procOn |=> state == ST_IDLE)
    else $error("handler started while process interrupts deselected");

  chk_call_base: assert property (@(posedge core_clk) disable iff (!rst_n)
    processIrqHandler |-> handlerBaseAddr == $past(baseAddr) && $past(state) == ST_IDLE)
    else $error("handler base address not captured at call");

  chk_word_on_call: assert property (@(posedge core_clk) disable iff (!rst_n)
    processIrqHandler |-> eventWord != 32'h0000_0000 ##1 state == ST_HELD)
    else $error("handler called with empty event word");

  chk_alarm_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_ALARM && ctrl[`CTRL_TRG_EDGE] && alarmEdge != 16'h0000
    |=> eventWord[31:16] == {$past(alarmEdge[7:0]), $past(alarmEdge[15:8])})
    else $error("alarm edge bytes wrong");

  chk_alarm_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_ALARM && rawWord != 32'h0000_0000 |=> eventWord[15:0] == 16'h0000)
    else $error("alarm bytes 10 and 11 not zero");

  chk_counter_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && rawWord != 32'h0000_0000
    |=> (eventWord & `COUNTER_ZERO_MASK) == 32'h0000_0000)
    else $error("fixed zero bits set in counter word");

  chk_counter_ovf: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && ctrl[`CTRL_TRG_OVF] && cntEvt.ovf[0]
    |=> eventWord[24+`EVB_OVF])
    else $error("counter 0 overflow flag missing");

  chk_counter_cmp: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && ctrl[`CTRL_TRG_CMP] && cntEvt.cmp[1]
    |=> eventWord[16+`EVB_CMP])
    else $error("counter 1 compare flag missing");

  chk_gate_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && ctrl[`CTRL_TRG_GATE] && gateOpenEv
    |=> eventWord[`EVB_GATE_OPEN] ##1 processIrqHandler == 1'b0)
    else $error("gate open flag missing");

  chk_held_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_HELD && !endWrite |=> $stable(eventWord))
    else $error("event word changed during handler");

  chk_end_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_HELD && endWrite |=> eventWord == 32'h0000_0000 && state == ST_IDLE)
    else $error("event word not cleared at handler end");

  chk_lost_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    lostEv && diagEn[0] |=> irqStatus[`STB_LOST])
    else $error("lost interrupt not flagged");

  chk_lost_dropped: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_HELD && pending == 32'h0000_0000 && (newEv & ~eventWord) == 32'h0000_0000
    |=> pending == 32'h0000_0000)
    else $error("lost event kept for a later call");

  chk_edge_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_ALARM && !ctrl[`CTRL_TRG_EDGE] |=> state == ST_IDLE)
    else $error("alarm edge raised handler with edge trigger off");

  chk_ovf_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && !ctrl[`CTRL_TRG_OVF]
    |=> (eventWord & 32'h0404_0404) == 32'h0000_0000)
    else $error("overflow flag set with overflow trigger off");

  chk_latch_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && cntEvt.latch3 |=> eventWord[`EVB_LATCH])
    else $error("counter 3 latch flag missing");

  chk_soft_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    fresh && mode == MODE_COUNTER && !softwareCountGate |=> eventWord[1:0] == 2'b00)
    else $error("gate flag set while software gate closed");

endmodule
